// ---- dptl_cfg.svh ----
// Timing counts, function codes and reset values for the drive protection trip logic
`ifndef DPTL_CFG_SVH
`define DPTL_CFG_SVH
`define DPTL_CLK_HZ           25000000
`define DPTL_TICK_SEC_DIV     10
`define DPTL_TICK_CYCLES      (`DPTL_CLK_HZ / `DPTL_TICK_SEC_DIV)
`define DPTL_FAN_MODE_TRIP    1'b0
`define DPTL_FAN_MODE_WARN    1'b1
`define DPTL_OUT_FAN_WARN     8'h08
`define DPTL_OUT_LOW_VOLT     8'h0B
`define DPTL_IN_TRIP_RESET    8'h03
`define DPTL_IN_OUT_BLOCK     8'h05
`define DPTL_UNDERVOLTAGE_TRIP_DELAY_RST    13'h0000
`define DPTL_BLK_DECEL_RST    13'h0000
`define DPTL_DECEL_MAX        13'h1770
`define DPTL_REG_FAN_MODE     4'h0
`define DPTL_REG_UNDERVOLTAGE_TRIP_DELAY    4'h1
`define DPTL_REG_BLK_DECEL    4'h2
`define DPTL_REG_IN_FUNC      4'h3
`define DPTL_REG_OUT_FUNC     4'h4
`define DPTL_REG_STATUS       4'h5
`define DPTL_REG_IRQ_STAT     4'h6
`define DPTL_REG_IRQ_MASK     4'h7
`define DPTL_REG_HOLD_FREQ    4'h8
`define DPTL_REG_HOLD_CURR    4'h9
`define DPTL_IRQ_FAN          0
`define DPTL_IRQ_LV           1
`define DPTL_IRQ_OVH          2
`define DPTL_IRQ_BLK          3
`endif

// ---- dptl_pkg.sv ----
// Types shared by the drive protection trip logic
package dptl_pkg;
	typedef enum logic [1:0] {DPTL_RUN, DPTL_DECEL, DPTL_BLOCKED} dptl_blk_state_t;
	typedef logic [12:0] dptl_tenths_t;
endpackage

// ---- dptl_tick.sv ----
// Fixed 0.1 s tick generator derived from the control clock
`include "dptl_cfg.svh"
module dptl_tick #(
	parameter int TICK_CYCLES = `DPTL_TICK_CYCLES
)(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Tick
	output logic      tick
);
	logic [31:0] cnt_reg;
	wire         wrap = (cnt_reg == 32'(TICK_CYCLES - 1));
	assign tick = wrap;
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			cnt_reg <= 32'h0;
		else
			cnt_reg <= wrap ? 32'h0 : cnt_reg + 32'h1;
	end
	tick_period_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		tick |=> !tick) else $error("tick lasted more than one cycle");
endmodule // dptl_tick

// ---- dptl_timer.sv ----
// Tenth-of-second countdown timer used for trip delay and deceleration
`include "dptl_cfg.svh"
module dptl_timer
	import dptl_pkg::*;
(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	// Control
	input  wire logic         tick,
	input  wire logic         start,
	input  wire logic         clear,
	input  wire dptl_tenths_t length,
	// Status
	output logic              done,
	output logic              busy
);
	dptl_tenths_t left_reg;
	logic         busy_reg;
	assign busy = busy_reg;
	assign done = busy_reg && tick && (left_reg <= 13'h0001);
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			left_reg <= 13'h0000;
			busy_reg <= 1'b0;
		end
		else if (clear)
		begin
			busy_reg <= 1'b0;
		end
		else if (start && !busy_reg)
		begin
			left_reg <= length;
			busy_reg <= (length != 13'h0000);
		end
		else if (done)
			busy_reg <= 1'b0;
		else if (busy_reg && tick)
			left_reg <= left_reg - 13'h0001;
	end
	timer_done_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		done |=> !busy) else $error("timer still busy after done");
endmodule // dptl_timer

// ---- dptl_trip.sv ----
// Drive protection trip logic: fan fault, undervoltage and output-block handling
// Functional notes
// - Fan fault in trip mode blocks output and latches a fan trip.
// - Fan fault in warning mode drives outputs with function 8; run continues.
// - In warning mode an overheat still blocks the output.
// - DC link undervoltage blocks output and raises a low voltage trip.
// - Nonzero trip delay: block at once, declare trip after the delay.
// - Outputs with function 11 show the low voltage warning.
// - The warning follows the undervoltage condition with no delay.
// - Block input with function 5 blocks output and shows block state.
// - Frequency and current captured at block assertion are held for monitoring.
// - Resume only after block input off and a new run command.
// - Zero block decel time: output cut at once, motor coasts.
// - Nonzero decel time, up to 600.0 s: motor decelerates over it.
// - Input with function 3 clears latched trips when it turns on.
`include "dptl_cfg.svh"
module dptl_trip
	import dptl_pkg::*;
#(
	parameter int N_IN       = 8,
	parameter int N_OUT      = 3,
	parameter int TICK_CYCLES = `DPTL_TICK_CYCLES
)(
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	// Sensors and run command
	input  wire logic             fan_error,
	input  wire logic             overheat,
	input  wire logic             dc_undervolt,
	input  wire logic             run_cmd,
	input  wire logic [15:0]      out_freq,
	input  wire logic [15:0]      out_curr,
	// Terminals
	input  wire logic [N_IN-1:0]  input_terminal,
	output logic [N_OUT-1:0]      output_terminal,
	// Drive control
	output logic                  output_enable,
	output logic                  decel_active,
	output logic                  block_shown,
	output logic                  fault_active,
	// Register port
	input  wire logic [3:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [31:0]           reg_rdata,
	// Interrupt
	output logic                  irq
);
	// Configuration registers
	logic                   fan_mode_reg;
	dptl_tenths_t           undervoltage_trip_delay_reg;
	dptl_tenths_t           block_decel_time_reg;
	logic [8*N_IN-1:0]      input_terminal_function_reg;
	logic [8*N_OUT-1:0]     output_function_reg;
	logic [3:0]             irq_stat_reg;
	logic [3:0]             irq_mask_reg;
	logic [31:0]            rdata_reg;
	// Trip and block state
	logic                   fan_trip_reg;
	logic                   lv_trip_reg;
	logic                   ovh_trip_reg;
	logic                   lv_block_reg;
	logic [N_IN-1:0]        in_prev_reg;
	logic                   run_prev_reg;
	logic [15:0]            hold_freq_reg;
	logic [15:0]            hold_curr_reg;
	dptl_blk_state_t        blk_state_reg;
	dptl_blk_state_t        blk_state_next;

	// Terminal function decode
	logic [N_IN-1:0]        in_is_reset;
	logic [N_IN-1:0]        in_is_block;
	logic [N_IN-1:0]        in_rise;
	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi++)
		begin : g_in
			wire [7:0] fn = input_terminal_function_reg[8*gi +: 8];
			assign in_is_reset[gi] = (fn == `DPTL_IN_TRIP_RESET);
			assign in_is_block[gi] = (fn == `DPTL_IN_OUT_BLOCK);
			assign in_rise[gi]     = input_terminal[gi] && !in_prev_reg[gi];
		end
	endgenerate

	wire tick;
	wire lv_timer_done;
	wire lv_timer_busy;
	wire dec_timer_done;
	wire dec_timer_busy;

	wire trip_reset   = |(in_rise & in_is_reset);
	wire block_in     = |(input_terminal & in_is_block);
	wire block_rise   = |(in_rise & in_is_block);
	wire run_rise     = run_cmd && !run_prev_reg;
	wire fan_warn_mode = (fan_mode_reg == `DPTL_FAN_MODE_WARN);
	wire fan_trip_set = fan_error && !fan_warn_mode;
	wire ovh_set      = overheat;
	wire lv_zero_delay = (undervoltage_trip_delay_reg == 13'h0000);
	wire lv_trip_set   = dc_undervolt && (lv_zero_delay ? 1'b1 : lv_timer_done);
	wire lv_warn      = dc_undervolt;
	wire fan_warn     = fan_error && fan_warn_mode;
	wire any_trip     = fan_trip_reg || lv_trip_reg || ovh_trip_reg;
	wire blk_out      = (blk_state_reg != DPTL_RUN);

	dptl_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.tick    (tick)
	);

	dptl_timer u_lv_timer (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.tick    (tick),
		.start   (dc_undervolt && !lv_trip_reg),
		.clear   (!dc_undervolt),
		.length  (undervoltage_trip_delay_reg),
		.done    (lv_timer_done),
		.busy    (lv_timer_busy)
	);

	dptl_timer u_dec_timer (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.tick    (tick),
		.start   (blk_state_reg == DPTL_DECEL),
		.clear   (blk_state_reg == DPTL_RUN),
		.length  (block_decel_time_reg),
		.done    (dec_timer_done),
		.busy    (dec_timer_busy)
	);

	// Multi-function output decode
	generate
		for (gi = 0; gi < N_OUT; gi++)
		begin : g_out
			wire [7:0] fn = output_function_reg[8*gi +: 8];
			assign output_terminal[gi] = ((fn == `DPTL_OUT_FAN_WARN) && fan_warn) ||
				((fn == `DPTL_OUT_LOW_VOLT) && lv_warn);
		end
	endgenerate

	// Output-block sequencing
	always_comb
	begin
		blk_state_next = blk_state_reg;
		case (blk_state_reg)
			DPTL_RUN:
				if (block_in)
					// Coast when decel time is zero
					blk_state_next = (block_decel_time_reg == 13'h0000) ? DPTL_BLOCKED : DPTL_DECEL;
			DPTL_DECEL:
				if (dec_timer_done)
					blk_state_next = DPTL_BLOCKED;
			DPTL_BLOCKED:
				// Resume on release plus new run
				if (!block_in && run_rise)
					blk_state_next = DPTL_RUN;
			default:
				blk_state_next = DPTL_BLOCKED;
		endcase
	end

	// Output blocked while any trip or undervoltage block stands
	assign output_enable = !any_trip && !lv_block_reg && (blk_state_reg != DPTL_BLOCKED);
	assign decel_active  = (blk_state_reg == DPTL_DECEL);
	assign block_shown   = blk_out;
	assign fault_active  = any_trip;
	assign irq           = |(irq_stat_reg & irq_mask_reg);
	assign reg_rdata     = rdata_reg;

	// Register decode
	wire wr_fan   = reg_wr && (reg_addr == `DPTL_REG_FAN_MODE);
	wire wr_lvd   = reg_wr && (reg_addr == `DPTL_REG_UNDERVOLTAGE_TRIP_DELAY);
	wire wr_dec   = reg_wr && (reg_addr == `DPTL_REG_BLK_DECEL);
	wire wr_inf   = reg_wr && (reg_addr == `DPTL_REG_IN_FUNC);
	wire wr_outf  = reg_wr && (reg_addr == `DPTL_REG_OUT_FUNC);
	wire wr_istat = reg_wr && (reg_addr == `DPTL_REG_IRQ_STAT);
	wire wr_imask = reg_wr && (reg_addr == `DPTL_REG_IRQ_MASK);
	wire [3:0] irq_evt = {block_rise, ovh_set, dc_undervolt, fan_error};
	wire [12:0] dec_wdata = (reg_wdata[12:0] > `DPTL_DECEL_MAX) ? `DPTL_DECEL_MAX : reg_wdata[12:0];
	wire [31:0] rd_mux =
		(reg_addr == `DPTL_REG_FAN_MODE)  ? {31'h0, fan_mode_reg} :
		(reg_addr == `DPTL_REG_UNDERVOLTAGE_TRIP_DELAY) ? {19'h0, undervoltage_trip_delay_reg} :
		(reg_addr == `DPTL_REG_BLK_DECEL) ? {19'h0, block_decel_time_reg} :
		(reg_addr == `DPTL_REG_IN_FUNC)   ? 32'(input_terminal_function_reg) :
		(reg_addr == `DPTL_REG_OUT_FUNC)  ? 32'(output_function_reg) :
		(reg_addr == `DPTL_REG_STATUS)    ? {24'h0, blk_state_reg == DPTL_DECEL, blk_out, lv_warn,
			fan_warn, lv_block_reg, ovh_trip_reg, lv_trip_reg, fan_trip_reg} :
		(reg_addr == `DPTL_REG_IRQ_STAT)  ? {28'h0, irq_stat_reg} :
		(reg_addr == `DPTL_REG_IRQ_MASK)  ? {28'h0, irq_mask_reg} :
		(reg_addr == `DPTL_REG_HOLD_FREQ) ? {16'h0, hold_freq_reg} :
		(reg_addr == `DPTL_REG_HOLD_CURR) ? {16'h0, hold_curr_reg} : 32'h0;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fan_mode_reg                <= `DPTL_FAN_MODE_TRIP;
			undervoltage_trip_delay_reg <= `DPTL_UNDERVOLTAGE_TRIP_DELAY_RST;
			block_decel_time_reg        <= `DPTL_BLK_DECEL_RST;
			input_terminal_function_reg <= '0;
			output_function_reg         <= '0;
			irq_mask_reg                <= 4'h0;
			rdata_reg                   <= 32'h0;
		end
		else
		begin
			if (wr_fan)
				fan_mode_reg <= reg_wdata[0];
			if (wr_lvd)
				undervoltage_trip_delay_reg <= dec_wdata;
			if (wr_dec)
				block_decel_time_reg <= dec_wdata;
			// Only the codes that fit in one bus word are writable
			if (wr_inf)
				input_terminal_function_reg <= (8*N_IN)'(reg_wdata);
			if (wr_outf)
				output_function_reg <= (8*N_OUT)'(reg_wdata);
			if (wr_imask)
				irq_mask_reg <= reg_wdata[3:0];
			rdata_reg <= reg_rd ? rd_mux : 32'h0;
		end
	end

	// Sticky interrupt status, set wins over write-one-to-clear
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			irq_stat_reg <= 4'h0;
		else
			irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? reg_wdata[3:0] : 4'h0)) | irq_evt;
	end

	// Latched trips cleared only by trip reset; a standing cause wins for all but a delayed low voltage trip, which clears and times again
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fan_trip_reg <= 1'b0;
			lv_trip_reg  <= 1'b0;
			ovh_trip_reg <= 1'b0;
			lv_block_reg <= 1'b0;
		end
		else
		begin
			fan_trip_reg <= fan_trip_set || (fan_trip_reg && !trip_reset);
			lv_trip_reg  <= lv_trip_set || (lv_trip_reg && !trip_reset);
			ovh_trip_reg <= ovh_set || (ovh_trip_reg && !trip_reset);
			// Block at once, before the trip is declared
			lv_block_reg <= dc_undervolt || (lv_block_reg && !trip_reset);
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			blk_state_reg <= DPTL_RUN;
			in_prev_reg   <= '0;
			run_prev_reg  <= 1'b0;
			hold_freq_reg <= 16'h0000;
			hold_curr_reg <= 16'h0000;
		end
		else
		begin
			blk_state_reg <= blk_state_next;
			in_prev_reg   <= input_terminal;
			run_prev_reg  <= run_cmd;
			if (blk_state_reg == DPTL_RUN && block_in)
			begin
				hold_freq_reg <= out_freq;
				hold_curr_reg <= out_curr;
			end
		end
	end

	// Assertions
	fan_trip_blk_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		fan_error && !fan_warn_mode |=> !output_enable && fault_active) else $error("fan trip missed");
	fan_warn_run_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		fan_warn && !fan_trip_reg |=> !fan_trip_reg) else $error("fan warning tripped");
	ovh_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		overheat |=> !output_enable) else $error("overheat did not block");
	lv_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		dc_undervolt |=> !output_enable) else $error("undervoltage did not block");
	lv_zero_trip_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		dc_undervolt && lv_zero_delay |=> lv_trip_reg) else $error("zero delay trip late");
	lv_warn_now_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		dc_undervolt && output_function_reg[7:0] == `DPTL_OUT_LOW_VOLT |-> output_terminal[0])
		else $error("low voltage warning delayed");
	blk_coast_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		blk_state_reg == DPTL_RUN && block_in && block_decel_time_reg == 13'h0000 |=> !output_enable)
		else $error("block did not cut output");
	blk_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		blk_state_reg == DPTL_RUN && block_in |=> hold_freq_reg == $past(out_freq))
		else $error("frequency not captured");
	blk_resume_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		blk_state_reg == DPTL_BLOCKED && !(run_rise && !block_in) |=> blk_state_reg == DPTL_BLOCKED)
		else $error("resumed without release and run");
	trip_latch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		fan_trip_reg && !trip_reset |=> fan_trip_reg) else $error("trip unlatched");
	lv_latch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		lv_trip_reg && !trip_reset |=> lv_trip_reg) else $error("low voltage trip unlatched");
	lv_delay_trip_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		dc_undervolt && !lv_zero_delay && !lv_timer_done && !lv_trip_reg |=> !lv_trip_reg)
		else $error("low voltage trip before delay");
	blk_shown_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		blk_state_reg == DPTL_RUN && block_in |=> block_shown)
		else $error("block state not shown");
	dec_run_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		dec_timer_busy && !dec_timer_done |=> blk_state_reg == DPTL_DECEL)
		else $error("deceleration ended early");
	cov_decel_c: cover property (@(posedge ref_clk) disable iff (!rstn)
		blk_state_reg == DPTL_DECEL ##1 blk_state_reg == DPTL_BLOCKED);
	cov_lv_delay_c: cover property (@(posedge ref_clk) disable iff (!rstn)
		lv_timer_busy ##1 lv_trip_reg);
	cov_reset_c: cover property (@(posedge ref_clk) disable iff (!rstn)
		any_trip ##1 trip_reset ##1 !any_trip);
	cov_fan_warn_c: cover property (@(posedge ref_clk) disable iff (!rstn)
		fan_warn && output_enable);
	cov_coast_c: cover property (@(posedge ref_clk) disable iff (!rstn)
		blk_state_reg == DPTL_RUN ##1 blk_state_reg == DPTL_BLOCKED);
endmodule // dptl_trip

// ---- dptl_field_model.sv ----
// Model of the control wiring: input terminals and run command
module dptl_field_model #(
	parameter int N_IN = 4
)(
	// Clock
	input  wire logic            ref_clk,
	// Terminals towards the drive
	output logic [N_IN-1:0]      input_terminal,
	output logic                 run_cmd
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		input_terminal = '0;
		run_cmd = 1'b0;
	end

	// Changes one terminal just after an edge
	task automatic set_term(input int idx, input logic val);
		@(posedge ref_clk);
		input_terminal[idx] <= val;
	endtask

	task automatic restart();
		@(posedge ref_clk);
		run_cmd <= 1'b0;
		@(posedge ref_clk);
		run_cmd <= 1'b1;
	endtask
endmodule // dptl_field_model

// ---- dptl_trip_bench.sv ----
// Self-checking bench for the drive protection trip logic
module dptl_trip_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        fan_error = 1'b0;
	logic        overheat = 1'b0;
	logic        dc_undervolt = 1'b0;
	logic        run_cmd;
	logic [15:0] out_freq = 16'h0000;
	logic [15:0] out_curr = 16'h0000;
	logic [3:0]  input_terminal;
	logic [2:0]  output_terminal;
	logic        output_enable;
	logic        decel_active;
	logic        block_shown;
	logic        fault_active;
	logic        irq;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h00000000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	int          fail_count = 0;
	int          compares = 0;

	always #20 ref_clk = ~ref_clk;

	dptl_field_model #(.N_IN(4)) field (.ref_clk(ref_clk), .input_terminal(input_terminal), .run_cmd(run_cmd));

	dptl_trip #(.N_IN(4), .N_OUT(3), .TICK_CYCLES(10)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .fan_error(fan_error), .overheat(overheat),
		.dc_undervolt(dc_undervolt), .run_cmd(run_cmd), .out_freq(out_freq), .out_curr(out_curr),
		.input_terminal(input_terminal), .output_terminal(output_terminal),
		.output_enable(output_enable), .decel_active(decel_active), .block_shown(block_shown),
		.fault_active(fault_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, exp, reg_rdata);
	endtask

	task automatic clear_trip();
		field.set_term(0, 1'b1);
		cyc(2);
		field.set_term(0, 1'b0);
		cyc(2);
	endtask

	task automatic t_defaults();
		chk("enable at rest", 32'h1, output_enable);
		rdchk("trip delay", 4'h1, 32'h0);
		rdchk("decel time", 4'h2, 32'h0);
		rdchk("unmapped", 4'hF, 32'h0);
		wr(4'h3, 32'h00000503);
		wr(4'h4, 32'h00080B08);
		rdchk("in func", 4'h3, 32'h00000503);
		rdchk("out func", 4'h4, 32'h00080B08);
		$display("test defaults done");
	endtask

	task automatic t_fan_trip();
		wr(4'h0, 32'h0);
		wr(4'h7, 32'h0);
		@(posedge ref_clk);
		fan_error <= 1'b1;
		cyc(2);
		chk("fan enable", 32'h0, output_enable);
		chk("fan fault", 32'h1, fault_active);
		clear_trip();
		chk("reset refused", 32'h1, fault_active);
		@(posedge ref_clk);
		fan_error <= 1'b0;
		cyc(3);
		chk("fan latched", 32'h0, output_enable);
		chk("irq masked", 32'h0, irq);
		rdchk("fan status", 4'h5, 32'h01);
		wr(4'h7, 32'h1);
		cyc(1);
		chk("irq on", 32'h1, irq);
		rdchk("irq stat", 4'h6, 32'h1);
		clear_trip();
		chk("reset enable", 32'h1, output_enable);
		wr(4'h6, 32'hF);
		cyc(1);
		chk("irq off", 32'h0, irq);
		$display("test fan trip done");
	endtask

	task automatic t_fan_warn();
		wr(4'h0, 32'h1);
		@(posedge ref_clk);
		fan_error <= 1'b1;
		#1;
		chk("fan warn out", 32'h5, output_terminal);
		cyc(3);
		chk("warn enable", 32'h1, output_enable);
		rdchk("warn status", 4'h5, 32'h10);
		@(posedge ref_clk);
		overheat <= 1'b1;
		cyc(2);
		chk("overheat enable", 32'h0, output_enable);
		@(posedge ref_clk);
		overheat <= 1'b0;
		fan_error <= 1'b0;
		cyc(1);
		clear_trip();
		chk("warn recovered", 32'h1, output_enable);
		wr(4'h0, 32'h0);
		$display("test fan warn done");
	endtask

	task automatic t_undervolt();
		wr(4'h1, 32'h3);
		@(posedge ref_clk);
		dc_undervolt <= 1'b1;
		#1;
		chk("lv warn out", 32'h2, output_terminal);
		cyc(2);
		chk("lv enable", 32'h0, output_enable);
		chk("lv early", 32'h0, fault_active);
		rdchk("lv pending", 4'h5, 32'h28);
		cyc(14);
		chk("lv delay", 32'h0, fault_active);
		for (int i = 0; i < 30 && fault_active !== 1'b1; i++)
			cyc(1);
		chk("lv trip", 32'h1, fault_active);
		rdchk("lv status", 4'h5, 32'h2A);
		@(posedge ref_clk);
		dc_undervolt <= 1'b0;
		#1;
		chk("lv warn gone", 32'h0, output_terminal);
		clear_trip();
		chk("lv recovered", 32'h1, output_enable);
		wr(4'h1, 32'h0);
		$display("test undervoltage done");
	endtask

	task automatic t_block_coast();
		field.restart();
		@(posedge ref_clk);
		out_freq <= 16'h1234;
		out_curr <= 16'h0567;
		field.set_term(1, 1'b1);
		cyc(2);
		chk("block shown", 32'h1, block_shown);
		chk("coast enable", 32'h0, output_enable);
		chk("coast decel", 32'h0, decel_active);
		@(posedge ref_clk);
		out_freq <= 16'hAAAA;
		out_curr <= 16'h5555;
		rdchk("held freq", 4'h8, 32'h1234);
		rdchk("held curr", 4'h9, 32'h0567);
		field.set_term(1, 1'b0);
		cyc(4);
		chk("no run yet", 32'h1, block_shown);
		field.restart();
		cyc(2);
		chk("resumed", 32'h0, block_shown);
		chk("resumed enable", 32'h1, output_enable);
		$display("test block coast done");
	endtask

	task automatic t_block_decel();
		wr(4'h2, 32'h00001B58);
		rdchk("decel clamp", 4'h2, 32'h00001770);
		// Five tenths is ample for the light bench load
		wr(4'h2, 32'h5);
		field.set_term(1, 1'b1);
		cyc(2);
		chk("decel start", 32'h1, decel_active);
		chk("decel drive", 32'h1, output_enable);
		cyc(30);
		chk("decel running", 32'h1, decel_active);
		cyc(40);
		chk("decel over", 32'h0, decel_active);
		chk("decel enable", 32'h0, output_enable);
		field.set_term(1, 1'b0);
		field.restart();
		cyc(2);
		chk("decel resumed", 32'h0, block_shown);
		wr(4'h2, 32'h0);
		$display("test block decel done");
	endtask

	initial
	begin
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		cyc(1);
		t_defaults();
		t_fan_trip();
		t_fan_warn();
		t_undervolt();
		t_block_coast();
		t_block_decel();
		final_report();
	end

	initial
	begin
		#400000;
		fail_count++;
		final_report();
	end
endmodule // dptl_trip_bench
